/* File: bench/crf_clock_reset_flags_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module crf_clock_reset_flags_tb_top;
    import crf_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0;
    logic lock = 0, por = 0, lvr = 0, ila = 0, pss = 0, fst = 0;
    wire logic [31:0] prd;
    wire logic [3:0] refd;
    wire logic [4:0] pdiv;
    wire logic [1:0] mode;
    wire logic prdy, perr, qual, irq, fp, plle, irce, apie, refo, oscillator_enable_bit, buso, cane;
    int mismatches = 0;
    int checks_done = 0;
    crf_clock_reset_flags crf_clock_reset_flags_inst (.CLK_SYS(clk), .RESETN(rstn), .CE(1'b1),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .PLL_LOCK_IN(lock), .OSC_QUALIFY_IN(qual),
        .POR_EVENT_IN(por), .LVR_EVENT_IN(lvr), .ILA_EVENT_IN(ila), .PSEUDO_STOP_IN(pss),
        .FULL_STOP_IN(fst), .IRQ(irq), .REGULATOR_FULL_POWER(fp), .PLL_ENABLE(plle),
        .INTERNAL_1MHZ_REFERENCE_EN(irce), .AUTONOMOUS_WAKEUP_TIMER_EN(apie),
        .PLL_REF_FROM_OSC(refo), .OSCILLATOR_ENABLE(oscillator_enable_bit), .BUS_CLK_FROM_OSC(buso),
        .REFERENCE_DIVIDER(refd), .PLL_OUTPUT_DIVIDE(pdiv), .CAN_OSC_CLK_EN(cane), .CLOCK_MODE(mode));
    crf_osc_model crf_osc_model_inst (.CLK_SYS(clk), .OSC_EN(oscillator_enable_bit), .QUALIFY(qual));
    initial forever #50 clk = ~clk;
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            stop_test();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        // let the written register settle before anyone looks at outputs
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp = 1'b0);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk(32'(e), 32'(eexp));
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    initial begin
        int n;
        tick(20);
        rstn <= 1'b1;
        rd(CRF_FLAGS_OFF, 32'h00);
        rd(CRF_IRQ_EN_OFF, 32'h00);
        rd(CRF_CLK_CTRL_OFF, 32'h01);
        rd(CRF_POST_DIV_OFF, 32'h03);
        rd(CRF_MODE_OFF, 32'h00);
        chk({fp, plle, irce, apie}, 32'hF);
        chk(pdiv, 32'h4);
        $display("test reset finished");
        por <= 1'b1;
        lvr <= 1'b1;
        ila <= 1'b1;
        tick(4);
        {por, lvr, ila} <= 3'h0;
        rd(CRF_FLAGS_OFF, 32'h64);
        wr(CRF_FLAGS_OFF, 32'h00);
        rd(CRF_FLAGS_OFF, 32'h64);
        wr(CRF_FLAGS_OFF, 32'h40);
        rd(CRF_FLAGS_OFF, 32'h24);
        wr(CRF_FLAGS_OFF, 32'h2D);
        rd(CRF_FLAGS_OFF, 32'h00);
        wr(CRF_MODE_OFF, 32'h02);
        rd(CRF_MODE_OFF, 32'h00);
        rd(12'h01C, 32'h00, 1'b1);
        $display("test reset flags finished");
        wr(CRF_IRQ_EN_OFF, 32'hFF);
        rd(CRF_IRQ_EN_OFF, 32'h92);
        wr(CRF_IRQ_EN_OFF, 32'h10);
        wr(CRF_POST_DIV_OFF, 32'h05);
        chk(pdiv, 32'h4);
        lock <= 1'b1;
        tick(4);
        rd(CRF_FLAGS_OFF, 32'h18);
        chk(irq, 32'h1);
        chk(pdiv, 32'h6);
        wr(CRF_FLAGS_OFF, 32'h10);
        rd(CRF_FLAGS_OFF, 32'h08);
        chk(irq, 32'h0);
        $display("test lock finished");
        wr(CRF_REF_DIV_OFF, 32'h07);
        wr(CRF_CLK_CTRL_OFF, 32'h03);
        chk({refo, mode}, 32'h5);
        n = 0;
        while (cane !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        wr(CRF_IRQ_EN_OFF, 32'h02);
        rd(CRF_FLAGS_OFF, 32'h0B);
        chk({irq, refd, buso}, 32'h2E);
        wr(CRF_CLK_CTRL_OFF, 32'h02);
        chk({buso, plle, mode}, 32'hE);
        rd(CRF_MODE_OFF, 32'h02);
        wr(CRF_FLAGS_OFF, 32'h02);
        lock <= 1'b0;
        tick(6);
        rd(CRF_FLAGS_OFF, 32'h12);
        chk({cane, buso, pdiv}, 32'h4);
        wr(CRF_FLAGS_OFF, 32'h12);
        lock <= 1'b1;
        tick(8);
        rd(CRF_FLAGS_OFF, 32'h1B);
        wr(CRF_FLAGS_OFF, 32'h12);
        pss <= 1'b1;
        tick(4);
        lock <= 1'b0;
        tick(6);
        rd(CRF_FLAGS_OFF, 32'h11);
        chk(cane, 32'h1);
        fst <= 1'b1;
        tick(6);
        rd(CRF_FLAGS_OFF, 32'h12);
        chk(cane, 32'h0);
        pss <= 1'b0;
        fst <= 1'b0;
        tick(4);
        wr(CRF_FLAGS_OFF, 32'h12);
        wr(CRF_CLK_CTRL_OFF, 32'h01);
        $display("test oscillator finished");
        wr(CRF_IRQ_EN_OFF, 32'h80);
        wr(CRF_TICK_PER_OFF, 32'h03);
        tick(8);
        chk(irq, 32'h1);
        wr(CRF_TICK_PER_OFF, 32'h00);
        wr(CRF_FLAGS_OFF, 32'h00);
        rd(CRF_FLAGS_OFF, 32'h80);
        wr(CRF_IRQ_EN_OFF, 32'h00);
        chk(irq, 32'h0);
        wr(CRF_FLAGS_OFF, 32'h80);
        rd(CRF_FLAGS_OFF, 32'h00);
        $display("test tick finished");
        stop_test();
    end
endmodule : crf_clock_reset_flags_tb_top
`default_nettype wire

/* File: bench/crf_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module crf_osc_model #(
    parameter int START_CYC = 6
) (
    input wire logic CLK_SYS,
    input wire logic OSC_EN,
    output logic QUALIFY
);
    int cnt = 0;
    // crystal start-up: qualifies only after START_CYC enabled cycles
    always @(posedge CLK_SYS) begin
        if (!OSC_EN) cnt <= 0;
        else if (cnt < START_CYC) cnt <= cnt + 1;
    end
    assign QUALIFY = OSC_EN && (cnt == START_CYC);
endmodule : crf_osc_model
`default_nettype wire

/* File: rtl/crf_clock_reset_flags.sv */
// Functional notes
// - run mode: regulator full, PLL, reference, timer on
// - after reset internal PLL mode, divider 0x03
// - internal mode uses 1 MHz reference, reconfigurable
// - PLL keeps running while bypassed
// - wait mode behaves exactly like run
// - tick flag bit 7, write-one clear, irq
// - power-on flag bit 6, write-one clear
// - low-voltage flag bit 5, write-one clear
// - lock change flag bit 4, irq
// - lock bit 3; divider 4 unlocked
// - illegal-address flag bit 2, write-one clear
// - qualified change flag bit 1, irq
// - qualified bit 0 gates CAN clock
// - PLL always runs for oscillator qualification
// - lock loss clears qualified, except pseudo stop
`timescale 1ns/10ps
`default_nettype none
module crf_clock_reset_flags
    import crf_pkg::*;
#(
    parameter int TICK_W = 16
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PLL_LOCK_IN,
    input wire logic OSC_QUALIFY_IN,
    input wire logic POR_EVENT_IN,
    input wire logic LVR_EVENT_IN,
    input wire logic ILA_EVENT_IN,
    input wire logic PSEUDO_STOP_IN,
    input wire logic FULL_STOP_IN,
    output logic IRQ,
    output logic REGULATOR_FULL_POWER,
    output logic PLL_ENABLE,
    output logic INTERNAL_1MHZ_REFERENCE_EN,
    output logic AUTONOMOUS_WAKEUP_TIMER_EN,
    output logic PLL_REF_FROM_OSC,
    output logic OSCILLATOR_ENABLE,
    output logic BUS_CLK_FROM_OSC,
    output logic [3:0] REFERENCE_DIVIDER,
    output logic [4:0] PLL_OUTPUT_DIVIDE,
    output logic CAN_OSC_CLK_EN,
    output logic [1:0] CLOCK_MODE
);
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    logic [4:0] pin_s;
    logic lock_s, oscq_s, por_s, lvr_s, ila_s;
    logic pseudo_s, full_s;
    logic por_d_reg, lvr_d_reg, ila_d_reg;
    logic [7:0] flags_reg, flags_next;
    logic [7:0] irq_en_reg;
    logic pll_sel_reg, osc_en_reg;
    logic [3:0] ref_div_reg;
    logic [4:0] post_div_reg;
    logic [TICK_W-1:0] tick_per_reg, tick_cnt_reg;
    logic lock_reg, qual_reg, qual_next;
    logic [31:0] prdata_reg;
    logic [31:0] rd_mux;
    crf_mode_e mode;

    crf_sync #(.WIDTH(5)) u_sync_a (
        .CLK_SYS(CLK_SYS),
        .RESETN(RESETN),
        .CE(CE),
        .d({PLL_LOCK_IN, OSC_QUALIFY_IN, POR_EVENT_IN, LVR_EVENT_IN, ILA_EVENT_IN}),
        .q(pin_s)
    );
    crf_sync #(.WIDTH(2)) u_sync_b (
        .CLK_SYS(CLK_SYS),
        .RESETN(RESETN),
        .CE(CE),
        .d({PSEUDO_STOP_IN, FULL_STOP_IN}),
        .q({pseudo_s, full_s})
    );
    assign {lock_s, oscq_s, por_s, lvr_s, ila_s} = pin_s;

    // apb decode
    wire setup_ph = PSEL & ~PENABLE;
    wire access_ph = PSEL & PENABLE;
    wire mapped = hit(PADDR, CRF_FLAGS_OFF) | hit(PADDR, CRF_IRQ_EN_OFF) | hit(PADDR, CRF_CLK_CTRL_OFF)
                | hit(PADDR, CRF_REF_DIV_OFF) | hit(PADDR, CRF_POST_DIV_OFF) | hit(PADDR, CRF_TICK_PER_OFF)
                | hit(PADDR, CRF_MODE_OFF);
    wire wr = access_ph & PWRITE & mapped;
    wire wr_flags = wr & hit(PADDR, CRF_FLAGS_OFF);
    wire wr_irq_en = wr & hit(PADDR, CRF_IRQ_EN_OFF);
    wire wr_clk = wr & hit(PADDR, CRF_CLK_CTRL_OFF);
    wire wr_ref = wr & hit(PADDR, CRF_REF_DIV_OFF);
    wire wr_post = wr & hit(PADDR, CRF_POST_DIV_OFF);
    wire wr_tick = wr & hit(PADDR, CRF_TICK_PER_OFF);
    assign PREADY = access_ph;
    assign PSLVERR = access_ph & ~mapped;

    // periodic tick: period of zero stops the timer
    wire tick_end = (tick_per_reg != '0) && (tick_cnt_reg == tick_per_reg);

    // qualification depends on the VCO reference; lock loss drops it except in pseudo stop
    assign qual_next = osc_en_reg & oscq_s & ~full_s & (lock_s | pseudo_s);

    // hardware set wins over the write-one clear
    wire [7:0] set_ev = {tick_end,
                         por_s & ~por_d_reg,
                         lvr_s & ~lvr_d_reg,
                         lock_s ^ lock_reg,
                         1'b0,
                         ila_s & ~ila_d_reg,
                         qual_next ^ qual_reg,
                         1'b0};
    wire [7:0] clr_ev = wr_flags ? (PWDATA[7:0] & CRF_STICKY_MASK) : 8'h00;
    assign flags_next = (flags_reg & ~clr_ev) | set_ev;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            flags_reg <= 8'h00;
            lock_reg <= 1'b0;
            qual_reg <= 1'b0;
            por_d_reg <= 1'b0;
            lvr_d_reg <= 1'b0;
            ila_d_reg <= 1'b0;
        end else if (CE) begin
            flags_reg <= flags_next;
            lock_reg <= lock_s;
            qual_reg <= qual_next;
            por_d_reg <= por_s;
            lvr_d_reg <= lvr_s;
            ila_d_reg <= ila_s;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tick_cnt_reg <= '0;
        end else if (CE) begin
            tick_cnt_reg <= (tick_end || tick_per_reg == '0) ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    // configuration registers; reset lands in internal PLL mode
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            irq_en_reg <= CRF_IRQ_EN_RST;
            pll_sel_reg <= 1'b1;
            osc_en_reg <= 1'b0;
            ref_div_reg <= CRF_REF_DIV_RST;
            post_div_reg <= CRF_POST_DIV_RST;
            tick_per_reg <= CRF_TICK_PER_RST;
        end else if (CE) begin
            if (wr_irq_en) begin
                irq_en_reg <= PWDATA[7:0] & CRF_IRQ_EN_MASK;
            end
            if (wr_clk) begin
                pll_sel_reg <= PWDATA[CRF_PLL_SELECT_BIT];
                osc_en_reg <= PWDATA[CRF_OSCEN_BIT];
            end
            if (wr_ref) begin
                ref_div_reg <= PWDATA[3:0];
            end
            if (wr_post) begin
                post_div_reg <= PWDATA[4:0];
            end
            if (wr_tick) begin
                tick_per_reg <= PWDATA[TICK_W-1:0];
            end
        end
    end

    // read data is captured in the setup phase
    wire [7:0] flags_view = {flags_reg[7:4], lock_reg, flags_reg[2:1], qual_reg};
    assign rd_mux = hit(PADDR, CRF_FLAGS_OFF) ? {24'h000000, flags_view} :
                    hit(PADDR, CRF_IRQ_EN_OFF) ? {24'h000000, irq_en_reg} :
                    hit(PADDR, CRF_CLK_CTRL_OFF) ? {30'h0, osc_en_reg, pll_sel_reg} :
                    hit(PADDR, CRF_REF_DIV_OFF) ? {28'h0000000, ref_div_reg} :
                    hit(PADDR, CRF_POST_DIV_OFF) ? {27'h0, post_div_reg} :
                    hit(PADDR, CRF_TICK_PER_OFF) ? {{(32-TICK_W){1'b0}}, tick_per_reg} :
                    hit(PADDR, CRF_MODE_OFF) ? {30'h0, mode} : 32'h00000000;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            prdata_reg <= 32'h00000000;
        end else if (CE && setup_ph && !PWRITE) begin
            prdata_reg <= rd_mux;
        end
    end
    assign PRDATA = prdata_reg;

    // mode: wait mode has no input here, so run and wait are identical
    assign mode = !pll_sel_reg ? CRF_MODE_BYPASS : (osc_en_reg ? CRF_MODE_PLL_EXT : CRF_MODE_PLL_INT);
    assign CLOCK_MODE = mode;

    assign REGULATOR_FULL_POWER = 1'b1;
    assign PLL_ENABLE = 1'b1;
    assign INTERNAL_1MHZ_REFERENCE_EN = 1'b1;
    assign AUTONOMOUS_WAKEUP_TIMER_EN = 1'b1;
    assign PLL_REF_FROM_OSC = osc_en_reg;
    assign OSCILLATOR_ENABLE = osc_en_reg;
    // in bypass the oscillator drives the bus only once qualified, else the PLL stays in charge
    assign BUS_CLK_FROM_OSC = ~pll_sel_reg & qual_reg;
    assign REFERENCE_DIVIDER = ref_div_reg;
    assign PLL_OUTPUT_DIVIDE = lock_reg ? post_div_reg + 5'h01 : CRF_UNLOCK_DIV;
    assign CAN_OSC_CLK_EN = qual_reg;
    assign IRQ = |(flags_reg & irq_en_reg);

    // assertions
    AST_TICK_SETS: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && tick_end |=> flags_reg[CRF_TICK_BIT])
        else $error("tick end did not set tick flag");
    AST_POR_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && flags_reg[CRF_POR_BIT] && !(wr_flags && PWDATA[CRF_POR_BIT]) |=> flags_reg[CRF_POR_BIT])
        else $error("power-on flag cleared without write of one");
    AST_LVR_SET: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && lvr_s && !lvr_d_reg |=> flags_reg[CRF_LVR_BIT])
        else $error("low-voltage flag not set");
    AST_LOCK_CHG: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && $changed(lock_reg) |-> flags_reg[CRF_LOCKCHG_BIT])
        else $error("lock change not flagged");
    AST_DIV_UNLOCK: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !lock_reg |-> PLL_OUTPUT_DIVIDE == CRF_UNLOCK_DIV)
        else $error("unlocked divider not four");
    AST_ILA_SET: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && ila_s && !ila_d_reg |=> flags_reg[CRF_ILA_BIT])
        else $error("illegal-address flag not set");
    AST_OSC_CHG: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && $changed(qual_reg) |-> flags_reg[CRF_OSCCHG_BIT])
        else $error("qualified change not flagged");
    AST_CAN_GATE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !qual_reg |-> !CAN_OSC_CLK_EN && !BUS_CLK_FROM_OSC)
        else $error("oscillator clock passed while unqualified");
    AST_LOCK_LOSS: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && !lock_s && !pseudo_s |=> !qual_reg)
        else $error("qualified kept after lock loss");
    AST_PLL_ON: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        PLL_ENABLE && REGULATOR_FULL_POWER && INTERNAL_1MHZ_REFERENCE_EN)
        else $error("run-mode resources switched off");
    AST_IRQ: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        flags_reg[CRF_TICK_BIT] && irq_en_reg[CRF_TICK_BIT] |-> IRQ)
        else $error("tick interrupt missing");
    // flag behaviour
    AST_TICK_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && flags_reg[CRF_TICK_BIT] && !(wr_flags && PWDATA[CRF_TICK_BIT]) |=> flags_reg[CRF_TICK_BIT])
        else $error("tick flag cleared without write of one");
    AST_TICK_OFF: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        tick_per_reg == '0 |-> !tick_end)
        else $error("tick ended with timer stopped");
    AST_TICK_RESTART: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && tick_end |=> tick_cnt_reg == '0)
        else $error("tick counter not restarted");
    AST_POR_SET: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && por_s && !por_d_reg |=> flags_reg[CRF_POR_BIT])
        else $error("power-on flag not set");
    AST_LVR_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && flags_reg[CRF_LVR_BIT] && !(wr_flags && PWDATA[CRF_LVR_BIT]) |=> flags_reg[CRF_LVR_BIT])
        else $error("low-voltage flag cleared without write of one");
    AST_ILA_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && flags_reg[CRF_ILA_BIT] && !(wr_flags && PWDATA[CRF_ILA_BIT]) |=> flags_reg[CRF_ILA_BIT])
        else $error("illegal-address flag cleared without write of one");
    AST_LOCKCHG_SET: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && lock_s != lock_reg |=> flags_reg[CRF_LOCKCHG_BIT])
        else $error("lock edge did not set change flag");
    AST_LOCKCHG_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && flags_reg[CRF_LOCKCHG_BIT] && !(wr_flags && PWDATA[CRF_LOCKCHG_BIT]) |=> flags_reg[CRF_LOCKCHG_BIT])
        else $error("lock change flag cleared without write of one");
    AST_OSCCHG_SET: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && qual_next != qual_reg |=> flags_reg[CRF_OSCCHG_BIT])
        else $error("qualified edge did not set change flag");
    AST_OSCCHG_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && flags_reg[CRF_OSCCHG_BIT] && !(wr_flags && PWDATA[CRF_OSCCHG_BIT]) |=> flags_reg[CRF_OSCCHG_BIT])
        else $error("qualified change flag cleared without write of one");
    AST_STATUS_SLOTS: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !flags_reg[CRF_LOCK_BIT] && !flags_reg[CRF_QUALIFIED_BIT])
        else $error("status bit stored as sticky flag");
    AST_IRQ_LOCK: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        flags_reg[CRF_LOCKCHG_BIT] && irq_en_reg[CRF_LOCKCHG_BIT] |-> IRQ)
        else $error("lock interrupt missing");
    AST_IRQ_OSC: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        flags_reg[CRF_OSCCHG_BIT] && irq_en_reg[CRF_OSCCHG_BIT] |-> IRQ)
        else $error("oscillator interrupt missing");
    AST_IRQ_QUIET: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (flags_reg & irq_en_reg) == 8'h00 |-> !IRQ)
        else $error("interrupt without enabled flag");
    AST_IRQ_EN_BITS: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (irq_en_reg & ~CRF_IRQ_EN_MASK) == 8'h00)
        else $error("reserved enable bit set");
    // clock tree
    AST_LOCK_VIEW: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE |=> lock_reg == $past(lock_s))
        else $error("lock status not tracking");
    AST_DIV_LOCK: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        lock_reg |-> PLL_OUTPUT_DIVIDE == post_div_reg + 5'h01)
        else $error("locked divider wrong");
    AST_INT_MODE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        pll_sel_reg && !osc_en_reg |-> CLOCK_MODE == 2'(CRF_MODE_PLL_INT))
        else $error("internal PLL mode not shown");
    AST_INT_REF: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !osc_en_reg |-> !PLL_REF_FROM_OSC && INTERNAL_1MHZ_REFERENCE_EN)
        else $error("reference not internal");
    AST_BYPASS_PLL: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !pll_sel_reg |-> PLL_ENABLE)
        else $error("PLL stopped while bypassed");
    AST_TIMER_ON: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        AUTONOMOUS_WAKEUP_TIMER_EN && REGULATOR_FULL_POWER)
        else $error("wakeup timer or regulator off");
    AST_FULL_STOP: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && full_s |=> !qual_reg)
        else $error("qualified kept in full stop");
    AST_OSC_OFF: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && !osc_en_reg |=> !qual_reg)
        else $error("qualified with oscillator off");
    AST_CAN_ON: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        qual_reg |-> CAN_OSC_CLK_EN)
        else $error("oscillator clock gated while qualified");
    AST_PSEUDO_KEEP: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CE && pseudo_s && osc_en_reg && oscq_s && !full_s |=> qual_reg)
        else $error("qualified lost in pseudo stop");
    // bus protocol
    AST_PREADY: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        access_ph |-> PREADY)
        else $error("no ready in access phase");
    AST_BUS_QUIET: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !access_ph |-> !PREADY && !PSLVERR)
        else $error("ready or error outside access phase");
    AST_UNMAPPED: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        access_ph && !mapped |-> PSLVERR)
        else $error("unmapped access without error");
    AST_PRDATA_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !(CE && setup_ph && !PWRITE) |=> $stable(PRDATA))
        else $error("read data changed outside read setup");
    // cover points
    COV_PBE: cover property (@(posedge CLK_SYS) disable iff (!RESETN) mode == CRF_MODE_BYPASS && BUS_CLK_FROM_OSC);
    COV_PEE: cover property (@(posedge CLK_SYS) disable iff (!RESETN) mode == CRF_MODE_PLL_EXT && lock_reg);
    COV_CLR: cover property (@(posedge CLK_SYS) disable iff (!RESETN) wr_flags ##1 flags_reg == 8'h00);
    COV_PSEUDO: cover property (@(posedge CLK_SYS) disable iff (!RESETN) pseudo_s && !lock_s && qual_reg);
    COV_FULL: cover property (@(posedge CLK_SYS) disable iff (!RESETN) full_s ##1 !qual_reg);
endmodule : crf_clock_reset_flags
`default_nettype wire

/* File: rtl/crf_pkg.sv */
package crf_pkg;
    // register byte offsets
    localparam logic [11:0] CRF_FLAGS_OFF = 12'h000;
    localparam logic [11:0] CRF_IRQ_EN_OFF = 12'h004;
    localparam logic [11:0] CRF_CLK_CTRL_OFF = 12'h008;
    localparam logic [11:0] CRF_REF_DIV_OFF = 12'h00C;
    localparam logic [11:0] CRF_POST_DIV_OFF = 12'h010;
    localparam logic [11:0] CRF_TICK_PER_OFF = 12'h014;
    localparam logic [11:0] CRF_MODE_OFF = 12'h018;
    // flag register bit positions
    localparam int CRF_TICK_BIT = 7;
    localparam int CRF_POR_BIT = 6;
    localparam int CRF_LVR_BIT = 5;
    localparam int CRF_LOCKCHG_BIT = 4;
    localparam int CRF_LOCK_BIT = 3;
    localparam int CRF_ILA_BIT = 2;
    localparam int CRF_OSCCHG_BIT = 1;
    localparam int CRF_QUALIFIED_BIT = 0;
    localparam logic [7:0] CRF_STICKY_MASK = 8'hF6;
    localparam logic [7:0] CRF_IRQ_EN_MASK = 8'h92;
    // clock control bit positions
    localparam int CRF_PLL_SELECT_BIT = 0;
    localparam int CRF_OSCEN_BIT = 1;
    // reset values
    localparam logic [7:0] CRF_IRQ_EN_RST = 8'h00;
    localparam logic [3:0] CRF_REF_DIV_RST = 4'h0;
    localparam logic [4:0] CRF_POST_DIV_RST = 5'h03;
    localparam logic [15:0] CRF_TICK_PER_RST = 16'h0000;
    localparam logic [4:0] CRF_UNLOCK_DIV = 5'h04;
    localparam int CRF_VCO_RST_MHZ = 64;
    typedef enum logic [1:0] {CRF_MODE_PLL_INT, CRF_MODE_PLL_EXT, CRF_MODE_BYPASS} crf_mode_e;
endpackage : crf_pkg

/* File: rtl/crf_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module crf_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    // the first stage feeds only the second
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else if (CE) begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
    assign q = q_reg;
endmodule : crf_sync
`default_nettype wire
